// ### pkg/apbwd_pkg.sv
// Constants and state types shared by the watchdog design files
package apbwd_pkg;

  // Register byte offsets within the 4 KB window
  localparam logic [11:0] OFF_RELOAD  = 12'h000;
  localparam logic [11:0] OFF_COUNT   = 12'h004;
  localparam logic [11:0] OFF_CTRL    = 12'h008;
  localparam logic [11:0] OFF_CLR     = 12'h00C;
  localparam logic [11:0] OFF_RAW     = 12'h010;
  localparam logic [11:0] OFF_MASKED  = 12'h014;
  localparam logic [11:0] OFF_LOCK    = 12'hC00;

  // Control field positions
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_RES_EN_BIT = 1;

  // Reset values and special values
  localparam logic [31:0] RELOAD_RST = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_RST  = 32'hFFFFFFFF;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [31:0] LOCK_KEY   = 32'h1ACCE551;
  localparam logic [31:0] ZERO_WORD  = 32'h00000000;
  localparam logic [31:0] LOCK_ON    = 32'h00000001;
  localparam logic [31:0] COUNT_ZERO = 32'h00000000;
  localparam logic [31:0] COUNT_ONE  = 32'h00000001;

  // State of the two-flop synchroniser (two independent bits)
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } apbwd_sync_t;

  // Whole state of the watchdog core
  typedef struct packed {
    logic [31:0] reload;
    logic [31:0] count;
    logic [1:0]  ctrl;
    logic        raw;
    logic        locked;
    logic        stopped;
    logic        irq;
    logic        res;
    logic [31:0] prdata;
  } apbwd_state_t;

endpackage

// ### rtl/apbwd_sync.sv
// Two-flop synchroniser for the count enable and count-domain reset pins
`timescale 1ns/1ps
module apbwd_sync
  import apbwd_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [1:0] async_i,
  output logic [1:0]      sync_o
);

  apbwd_sync_t st;
  apbwd_sync_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule

// ### rtl/apbwd_top.sv
// Watchdog timer with APB register slave and write-protect lock
// What this block does
// - Writing the reload register restarts the counter from the new value.
// - Reload of zero raises the interrupt at the next tick; one is minimum.
// - Current-count register is read-only and returns the live counter.
// - Control bit 1 gates the timeout reset output.
// - Control bit 0 enables counting and interrupt; bits 31..2 reserved.
// - Enabling control bit 0 from low loads the counter from reload.
// - Any write to the clear location clears interrupt and reloads counter.
// - Raw status bit 0 is set when counter hits zero with control bit 0 set.
// - Masked status equals raw AND enable and drives the interrupt pin.
// - Writing the key to the lock register enables writes elsewhere.
// - Any other lock value blocks other writes; lock stays writable.
// - Lock read returns 0 when unlocked and 1 when locked.
// - Reset: reload and count all ones; control, status, lock zero.
// - Registers at 0x00..0x14 by four, lock at 0xC00, rest reserved.
// - Only address bits 11..2 are decoded.
// - Timeout reset and interrupt outputs are active high.
// - Count-domain reset is active low and clears the counting logic.
// - Counter decrements only on clock edges with count enable high.
// - Second zero with interrupt pending asserts reset if gated; then stop.
// - Clear write drops the interrupt at once, not on a count tick.
// - With control bit 0 low the counter holds its value.
`timescale 1ns/1ps
module apbwd_top
  import apbwd_pkg::*;
(
  // Clock and bus reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:2] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  // Counting pins
  input  wire logic        count_clock_enable_i,
  input  wire logic        count_domain_reset_n_i,
  // Watchdog outputs
  output logic             timeout_irq_out_o,
  output logic             timeout_reset_out_o
);

  apbwd_state_t st;
  apbwd_state_t next_st;

  logic [1:0]  sync_q;
  logic        tick;
  logic        cnt_rst;
  logic        wr_acc;
  logic        rd_setup;
  logic        wr_open;
  logic        wr_reload;
  logic        wr_ctrl;
  logic        wr_clr;
  logic        wr_lock;
  logic        running;
  logic        at_zero;
  logic        set_irq;
  logic        en_rise;

  // Address match on bits 11..2 only
  function automatic logic hit(input logic [11:2] a, input logic [11:0] off);
    hit = (a == off[11:2]);
  endfunction

  // Read mux; unmapped and write-only offsets give zero
  function automatic logic [31:0] read_word(input logic [11:2] a,
                                            input apbwd_state_t s);
    read_word = ZERO_WORD;
    if (hit(a, OFF_RELOAD)) begin
      read_word = s.reload;
    end else if (hit(a, OFF_COUNT)) begin
      read_word = s.count;
    end else if (hit(a, OFF_CTRL)) begin
      read_word = {30'h00000000, s.ctrl};
    end else if (hit(a, OFF_RAW)) begin
      read_word = {31'h00000000, s.raw};
    end else if (hit(a, OFF_MASKED)) begin
      read_word = {31'h00000000, s.raw & s.ctrl[CTRL_IRQ_EN_BIT]};
    end else if (hit(a, OFF_LOCK)) begin
      read_word = s.locked ? LOCK_ON : ZERO_WORD;
    end
  endfunction

  // Count enable and count-domain reset pins pass two flops before use; bus pins do not
  apbwd_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({count_domain_reset_n_i, count_clock_enable_i}),
    .sync_o  (sync_q)
  );

  // Bus strobes; the master keeps select and one-cycle enable framing
  assign wr_acc    = psel_i && penable_i && pwrite_i;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign wr_open   = wr_acc && !st.locked;
  assign wr_reload = wr_open && hit(paddr_i, OFF_RELOAD);
  assign wr_ctrl   = wr_open && hit(paddr_i, OFF_CTRL);
  assign wr_clr    = wr_open && hit(paddr_i, OFF_CLR);
  assign wr_lock   = wr_acc && hit(paddr_i, OFF_LOCK);

  // Count events
  assign cnt_rst = !sync_q[1];
  assign tick    = sync_q[0] && !cnt_rst;
  assign running = st.ctrl[CTRL_IRQ_EN_BIT] && !st.stopped;
  assign at_zero = (st.count == COUNT_ZERO);
  // A zero raises the interrupt unless it is the missed-service zero
  assign set_irq = tick && running && at_zero
                   && !(st.raw && st.ctrl[CTRL_RES_EN_BIT]);
  assign en_rise = wr_ctrl && !st.ctrl[CTRL_IRQ_EN_BIT]
                   && pwdata_i[CTRL_IRQ_EN_BIT];

  // Next-state logic: count tick first, bus writes override it
  always_comb begin
    next_st = st;
    if (cnt_rst) begin
      // Counting state cleared; reload and control belong to bus reset
      next_st.count   = COUNT_RST;
      next_st.raw     = 1'b0;
      next_st.stopped = 1'b0;
    end else if (tick && running) begin
      if (!at_zero) begin
        next_st.count = st.count - COUNT_ONE;
      end else if (set_irq) begin
        // Zero reached: raise the interrupt and start a new period
        next_st.count = st.reload;
        next_st.raw   = 1'b1;
      end else begin
        // Missed service with the gate on: halt at zero until reset
        next_st.stopped = 1'b1;
      end
    end
    // Reload write restarts the count but leaves the interrupt alone
    if (wr_reload) begin
      next_st.reload = pwdata_i;
      next_st.count  = pwdata_i;
    end
    if (wr_ctrl) begin
      next_st.ctrl = pwdata_i[1:0];
    end
    if (en_rise) begin
      next_st.count = st.reload;
    end
    // Clear: a zero reached in the same cycle still wins
    if (wr_clr) begin
      next_st.count = st.reload;
      next_st.raw   = set_irq;
    end
    if (wr_lock) begin
      next_st.locked = (pwdata_i != LOCK_KEY);
    end
    // Read data captured in setup so it is steady in the access phase
    if (rd_setup) begin
      next_st.prdata = read_word(paddr_i, st);
    end
    // Outputs registered from the new state, so a clear drops irq at once
    next_st.irq = next_st.raw && next_st.ctrl[CTRL_IRQ_EN_BIT];
    // Reset output is the stop flag masked by the gate, so clearing the
    // gate bit withdraws it; only a counting reset or bus reset clears the stop itself
    next_st.res = next_st.stopped && next_st.ctrl[CTRL_RES_EN_BIT];
  end

  // State register; all fields take constants under reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.reload  <= RELOAD_RST;
      st.count   <= COUNT_RST;
      st.ctrl    <= CTRL_RST;
      st.raw     <= 1'b0;
      st.locked  <= 1'b0;
      st.stopped <= 1'b0;
      st.irq     <= 1'b0;
      st.res     <= 1'b0;
      st.prdata  <= ZERO_WORD;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops, active high
  assign prdata_o            = st.prdata;
  assign timeout_irq_out_o   = st.irq;
  assign timeout_reset_out_o = st.res;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reload_restart: assert property (
    wr_reload |=> st.count == $past(pwdata_i))
    else $error("reload write did not restart counter");

  a_zero_raises: assert property (
    (tick && running && at_zero && !wr_clr && !cnt_rst) |=> st.raw)
    else $error("zero count did not raise interrupt");

  a_count_read: assert property (
    (rd_setup && hit(paddr_i, OFF_COUNT)) |=> prdata_o == $past(st.count))
    else $error("count read mismatch");

  a_reset_gated: assert property (
    $rose(timeout_reset_out_o) |-> st.ctrl[CTRL_RES_EN_BIT] && st.stopped)
    else $error("timeout reset rose while gated off");

  a_enable_load: assert property (
    (en_rise && !wr_clr) |=> st.count == $past(st.reload))
    else $error("enable did not load counter");

  a_clear_drop: assert property (
    (wr_clr && !set_irq) |=> !timeout_irq_out_o && !st.raw)
    else $error("clear did not drop interrupt");

  a_masked_pin: assert property (
    timeout_irq_out_o == (st.raw && st.ctrl[CTRL_IRQ_EN_BIT]))
    else $error("interrupt pin differs from masked status");

  a_lock_read: assert property (
    (rd_setup && hit(paddr_i, OFF_LOCK))
      |=> prdata_o == {31'h00000000, $past(st.locked)})
    else $error("lock read mismatch");

  a_locked_block: assert property (
    (wr_acc && st.locked && hit(paddr_i, OFF_CTRL)) |=> $stable(st.ctrl))
    else $error("locked write changed control");

  a_freeze_hold: assert property (
    (!st.ctrl[CTRL_IRQ_EN_BIT] && !wr_acc && !cnt_rst) |=> $stable(st.count))
    else $error("counter moved while disabled");

  a_decrement: assert property (
    (tick && running && !at_zero && !wr_acc)
      |=> st.count == $past(st.count) - COUNT_ONE)
    else $error("counter did not decrement by one");

  a_stop_after: assert property (
    (timeout_reset_out_o && !cnt_rst && !wr_acc) |=> $stable(st.count))
    else $error("counter ran after timeout reset");

  a_reset_mask: assert property (
    timeout_reset_out_o |-> st.ctrl[CTRL_RES_EN_BIT])
    else $error("timeout reset high with gate off");

  a_gate_off: assert property (
    (!st.ctrl[CTRL_RES_EN_BIT] && !wr_ctrl) |=> !timeout_reset_out_o)
    else $error("timeout reset rose while gate stays off");

  a_reset_stop: assert property (
    timeout_reset_out_o |-> st.stopped)
    else $error("timeout reset without a stopped counter");

  a_stop_sets: assert property (
    (tick && running && at_zero && st.raw && st.ctrl[CTRL_RES_EN_BIT]
      && !wr_acc) |=> timeout_reset_out_o && st.stopped)
    else $error("missed service did not raise timeout reset");

  a_stopped_hold: assert property (
    (st.stopped && !cnt_rst) |=> st.stopped)
    else $error("counter restarted without a counting reset");

  a_enable_gate: assert property (
    (!st.ctrl[CTRL_IRQ_EN_BIT] && !wr_ctrl) |=> !timeout_irq_out_o)
    else $error("interrupt raised while disabled");

  a_ctrl_write: assert property (
    wr_ctrl |=> st.ctrl == $past(pwdata_i[1:0]))
    else $error("control write not taken");

  a_ctrl_read: assert property (
    (rd_setup && hit(paddr_i, OFF_CTRL))
      |=> prdata_o == {30'h00000000, $past(st.ctrl)})
    else $error("control read mismatch");

  a_raw_sticky: assert property (
    (st.raw && !wr_clr && !cnt_rst) |=> st.raw)
    else $error("raw status dropped without a clear");

  a_raw_read: assert property (
    (rd_setup && hit(paddr_i, OFF_RAW))
      |=> prdata_o == {31'h00000000, $past(st.raw)})
    else $error("raw status read mismatch");

  a_masked_read: assert property (
    (rd_setup && hit(paddr_i, OFF_MASKED))
      |=> prdata_o == {31'h00000000, $past(timeout_irq_out_o)})
    else $error("masked status read differs from pin");

  a_reload_write: assert property (
    wr_reload |=> st.reload == $past(pwdata_i))
    else $error("reload write not taken");

  a_reload_read: assert property (
    (rd_setup && hit(paddr_i, OFF_RELOAD))
      |=> prdata_o == $past(st.reload))
    else $error("reload read mismatch");

  a_clear_read: assert property (
    (rd_setup && hit(paddr_i, OFF_CLR))
      |=> prdata_o == ZERO_WORD)
    else $error("write-only offset read not zero");

  a_reserved_read: assert property (
    (rd_setup && (paddr_i > OFF_MASKED[11:2]) && !hit(paddr_i, OFF_LOCK))
      |=> prdata_o == ZERO_WORD)
    else $error("reserved offset read not zero");

  a_unlock_key: assert property (
    (wr_lock && pwdata_i == LOCK_KEY) |=> !st.locked)
    else $error("key write did not unlock");

  a_lock_other: assert property (
    (wr_lock && pwdata_i != LOCK_KEY) |=> st.locked)
    else $error("non-key write did not lock");

  a_lock_open: assert property (
    (wr_lock && st.locked && pwdata_i == LOCK_KEY) |=> !st.locked)
    else $error("lock register not writable while locked");

  a_locked_reload: assert property (
    (wr_acc && st.locked && hit(paddr_i, OFF_RELOAD)) |=> $stable(st.reload))
    else $error("locked write changed reload");

  a_clear_locked: assert property (
    (wr_acc && st.locked && hit(paddr_i, OFF_CLR) && st.raw && !cnt_rst)
      |=> st.raw)
    else $error("locked clear write dropped the interrupt");

  a_clear_reload: assert property (
    wr_clr |=> st.count == $past(st.reload))
    else $error("clear did not reload counter");

  a_counter_reset: assert property (
    (cnt_rst && !wr_acc)
      |=> st.count == COUNT_RST && !st.raw && !timeout_reset_out_o)
    else $error("counting reset did not clear counter state");

  a_idle_tick: assert property (
    (!tick && !wr_acc && !cnt_rst) |=> $stable(st.count))
    else $error("counter moved without an enabled tick");

  a_zero_reload: assert property (
    (set_irq && !wr_acc) |=> st.count == $past(st.reload) && st.raw)
    else $error("zero did not reload and raise interrupt");

endmodule

// ### verification/apbwd_master.sv
// APB bridge model that drives the watchdog register slave
`timescale 1ns/1ps
module apbwd_master
  import apbwd_pkg::*;
(
  // Clock
  input  wire logic        clock_i,
  // APB master side
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:2]      paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i
);
  // Idle bus at time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 10'h000;
    pwdata_o  = 32'h00000000;
  end

  // One setup and one access cycle; read data taken at the access edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(negedge clock_i);
    psel_o    = 1'b1;
    pwrite_o  = wr;
    paddr_o   = a[11:2];
    pwdata_o  = wd;
    @(negedge clock_i);
    penable_o = 1'b1;
    @(posedge clock_i);
    rd = prdata_i;
    @(negedge clock_i);
    psel_o    = 1'b0;
    penable_o = 1'b0;
    // Released lines flip so a stale value is never mistaken for live
    paddr_o   = ~paddr_o;
    pwdata_o  = ~pwdata_o;
  endtask
endmodule

// ### verification/apbwd_top_test.sv
// Self-checking bench for the watchdog against a behavioural reference
`timescale 1ns/1ps
module apbwd_top_test
  import apbwd_pkg::*;
();
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cen     = 1'b0;
  logic        cdr_n   = 1'b1;
  logic        psel, penable, pwrite, irq, res;
  logic [11:2] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          failures = 0;
  int          compares = 0;
  int          seed     = 32'h4EE95B43;
  // Reference state
  bit [31:0]   m_reload = RELOAD_RST;
  bit [31:0]   m_count  = COUNT_RST;
  bit [31:0]   v;
  bit [1:0]    m_ctrl;
  bit          m_raw, m_locked, m_stop, m_res;
  logic [11:0] offs [9] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                            12'h014, 12'h018, 12'hBFC, 12'hC00};

  always #10 clock_i = ~clock_i;

  apbwd_master u_master (.clock_i(clock_i), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata));

  apbwd_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .count_clock_enable_i(cen),
    .count_domain_reset_n_i(cdr_n), .timeout_irq_out_o(irq),
    .timeout_reset_out_o(res));

  task automatic cmp_word(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic cmp_pin(input string n, input logic e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask

  // One enabled count edge of the reference
  task automatic m_tick();
    if (m_ctrl[0] && !m_stop) begin
      if (m_count != 0) m_count--;
      else if (m_raw && m_ctrl[1]) begin
        m_res  = 1'b1;
        m_stop = 1'b1;
      end else begin
        m_raw   = 1'b1;
        m_count = m_reload;
      end
    end
  endtask

  // Write through the bus and mirror it, lock permitting
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_master.xfer(1'b1, a, d, rd);
    if (a == OFF_LOCK) m_locked = (d != LOCK_KEY);
    else if (!m_locked) begin
      if (a == OFF_RELOAD) begin
        m_reload = d;
        m_count  = d;
      end
      if (a == OFF_CTRL) begin
        if (!m_ctrl[0] && d[0]) m_count = m_reload;
        m_ctrl = d[1:0];
      end
      if (a == OFF_CLR) begin
        m_raw   = 1'b0;
        m_count = m_reload;
      end
    end
  endtask

  function automatic bit [31:0] m_read(input logic [11:0] a);
    case (a)
      OFF_RELOAD: return m_reload;
      OFF_COUNT:  return m_count;
      OFF_CTRL:   return {30'h0, m_ctrl};
      OFF_RAW:    return {31'h0, m_raw};
      OFF_MASKED: return {31'h0, m_raw & m_ctrl[0]};
      OFF_LOCK:   return {31'h0, m_locked};
      default:    return ZERO_WORD;
    endcase
  endfunction

  // Read every register, two reserved offsets and both pins against the reference
  task automatic check_all();
    foreach (offs[i]) begin
      u_master.xfer(1'b0, offs[i], ZERO_WORD, rd);
      cmp_word($sformatf("reg %h", offs[i]), m_read(offs[i]), rd);
    end
    cmp_pin("irq pin", m_raw & m_ctrl[0], irq);
    cmp_pin("reset pin", m_res & m_ctrl[1], res);
  endtask

  // n enabled count edges, then settle past the synchroniser
  task automatic tick(input int n);
    @(negedge clock_i);
    cen = 1'b1;
    repeat (n) @(negedge clock_i);
    cen = 1'b0;
    repeat (4) @(negedge clock_i);
    repeat (n) m_tick();
  endtask

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check_all();
    wr(OFF_COUNT, $random(seed));
    wr(12'h018, $random(seed));
    wr(OFF_RELOAD, $random(seed));
    check_all();
    wr(OFF_RELOAD, 32'h00000003);
    wr(OFF_CTRL, 32'hFFFFFFFD);
    tick(2);
    check_all();
    tick(2);
    check_all();
    tick(4);
    check_all();
    wr(OFF_CLR, $random(seed));
    check_all();
    tick(4);
    wr(OFF_CTRL, 32'h00000000);
    tick(3);
    check_all();
    wr(OFF_CTRL, 32'h00000003);
    tick(4);
    check_all();
    wr(OFF_CTRL, 32'h00000001);
    check_all();
    // Counting reset leaves reload, control and lock alone
    cdr_n = 1'b0;
    repeat (4) @(negedge clock_i);
    cdr_n = 1'b1;
    repeat (4) @(negedge clock_i);
    {m_count, m_raw, m_stop, m_res} = {COUNT_RST, 3'b000};
    check_all();
    wr(OFF_RELOAD, ZERO_WORD);
    tick(1);
    check_all();
    v = $random(seed);
    if (v == LOCK_KEY) v = ~v;
    wr(OFF_LOCK, v);
    wr(OFF_RELOAD, $random(seed));
    wr(OFF_CLR, $random(seed));
    check_all();
    wr(OFF_LOCK, LOCK_KEY);
    wr(OFF_RELOAD, $random(seed));
    check_all();
    give_verdict();
  end
endmodule
